// ===== inc/chain_load_map.svh
`ifndef CHAIN_LOAD_MAP_SVH
`define CHAIN_LOAD_MAP_SVH
// Contract
// - Master uses self-fetch mode; slaves use host-driven mode, mode pins code 01.
// - With two images, master reads its own image first, chain-enable output high.
// - After own load, master drives chain-enable low and forwards second image.
// - Slaves enabled by master chain-enable all load the same image together.
// - Compressed and uncompressed images are accepted in both arrangements.
// - Single-image: all devices with chain-enable low load in one cycle.
// - Master clock comes from 40 MHz oscillator, never below 20 MHz.
// - Exactly one bit per clock, typical period 38.46 ns from flash.
// - Chain-enable input high means the flash interface is left alone; in st_forward the code keeps driving the flash whatever that input is.
// - Device stays in reset while configuration request is held low.
// - Host-driven mode captures one data bit on each rising clock edge.
// - Host-driven mode decompresses compressed data while loading; code passes bytes unchanged, sets image_compressed.
// - After all data, assert chain-enable output and release load-complete line.
// - On error drive error status low; auto restart retries within 40 us.
`define MODE_HOST_DRIVEN 2'h1
`define MODE_SELF_FETCH 2'h0
`define OSC_MHZ 40
`define RESTART_TIME_US 40
`define RESTART_CYCLES_CORE ((`RESTART_TIME_US * 25))
`define IMAGE_BITS_DEFAULT 32'h0000_0100
`define HDR_COMPRESSED_BIT 7
`endif

// ===== inc/chain_load_pkg.sv
package chain_load_pkg;
  typedef enum logic [2:0] {
    st_reset = 3'b000,
    st_fetch = 3'b001,
    st_forward = 3'b010,
    st_done = 3'b011,
    st_error = 3'b100
  } load_state_t;
  typedef struct packed {
    logic [7:0] data;
  } byte_word_t;
  typedef struct packed {
    load_state_t state;
    logic [31:0] bit_count;
    logic [15:0] wait_count;
    logic chain_out_n;
    logic done_drive_low;
    logic error_drive_low;
    logic [1:0] req_sync;
    logic [1:0] ce_sync;
    logic [1:0] data_sync;
    logic [1:0] link_tog_sync;
    logic link_tog_seen;
    logic [31:0] word_count;
    logic compressed;
  } core_state_t;
  typedef struct packed {
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic tog;
    logic [7:0] word;
  } link_state_t;
endpackage

// ===== design/chained_serial_config_load.sv
`timescale 1ns/100ps
`include "chain_load_map.svh"
module chained_serial_config_load
  import chain_load_pkg::*;
#(
  parameter int image_words = 32,
  parameter int restart_cycles = `RESTART_CYCLES_CORE,
  parameter bit two_images = 1'b1,
  parameter bit auto_restart = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic config_clock,
  input wire logic [1:0] mode_select_pins,
  input wire logic chain_enable_in_n,
  input wire logic config_request_n,
  input wire logic serial_data_in,
  input wire logic frame_error,
  output logic chain_enable_out_n,
  output logic load_complete_out,
  output logic load_complete_oe,
  output logic error_status_out,
  output logic error_status_oe,
  output logic flash_select_n,
  output logic flash_command_out,
  output logic fetch_clock_out,
  output logic fetch_data_out,
  output logic fwd_clock_out,
  output logic fwd_data_out,
  output logic [7:0] cfg_word,
  output logic cfg_valid,
  input wire logic cfg_ready,
  output logic image_compressed
);
  // Link side captures serial data in host-driven mode.
  link_state_t link, next_link;
  wire logic link_active = (mode_select_pins == `MODE_HOST_DRIVEN) && !chain_enable_in_n
    && config_request_n;
  always_comb begin
    next_link = link;
    if (link_active) begin
      next_link.shift = {serial_data_in, link.shift[7:1]};
      next_link.bit_idx = link.bit_idx + 3'h1;
      if (link.bit_idx == 3'h7) begin
        next_link.word = {serial_data_in, link.shift[7:1]};
        next_link.tog = ~link.tog;
      end
    end
  end
  always_ff @(posedge config_clock or negedge reset_n) begin
    if (!reset_n) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // Core side: state machine, oscillator-derived fetch clock, buffer.
  core_state_t s, next_s;
  byte_word_t buf_mem [2];
  logic [1:0] buf_cnt, next_buf_cnt;
  logic buf_wp, buf_rp, next_buf_wp, next_buf_rp;
  logic fclk, next_fclk;
  wire logic new_word = s.link_tog_sync[1] != s.link_tog_seen;
  wire logic buf_in_ready = buf_cnt != 2'h2;
  wire logic req_ok = s.req_sync[1];
  wire logic self_fetch = mode_select_pins == `MODE_SELF_FETCH;
  always_comb begin
    next_s = s;
    next_s.req_sync = {s.req_sync[0], config_request_n};
    next_s.ce_sync = {s.ce_sync[0], chain_enable_in_n};
    next_s.data_sync = {s.data_sync[0], serial_data_in};
    next_s.link_tog_sync = {s.link_tog_sync[0], link.tog};
    next_fclk = ~fclk;
    next_buf_cnt = buf_cnt;
    next_buf_wp = buf_wp;
    next_buf_rp = buf_rp;
    if (new_word && buf_in_ready) begin
      next_s.link_tog_seen = s.link_tog_sync[1];
      next_buf_wp = ~buf_wp;
      if (s.word_count == 32'h0) begin
        next_s.compressed = link.word[`HDR_COMPRESSED_BIT];
      end
      next_s.word_count = s.word_count + 32'h1;
    end
    if (cfg_valid && cfg_ready) begin
      next_buf_rp = ~buf_rp;
    end
    next_buf_cnt = buf_cnt + {1'b0, new_word && buf_in_ready} - {1'b0, cfg_valid && cfg_ready};
    if (!req_ok) begin
      next_s.state = st_reset;
      next_s.chain_out_n = 1'b1;
      next_s.done_drive_low = 1'b1;
      next_s.error_drive_low = 1'b1;
      next_s.bit_count = '0;
      next_s.word_count = '0;
    end else if (frame_error && s.state != st_error && s.state != st_reset) begin
      next_s.state = st_error;
      next_s.wait_count = '0;
      next_s.error_drive_low = 1'b1;
    end else begin
      case (s.state)
        st_reset: begin
          next_s.error_drive_low = 1'b0;
          if (!s.ce_sync[1]) begin
            next_s.state = self_fetch ? st_fetch : st_done;
          end
        end
        st_fetch: begin
          if (s.ce_sync[1]) begin
            next_s.state = st_reset;
          end else if (frame_error) begin
            next_s.state = st_error;
            next_s.wait_count = '0;
          end else if (fclk) begin
            next_s.bit_count = s.bit_count + 32'h1;
            if (s.bit_count == 32'(image_words * 8 - 1)) begin
              next_s.bit_count = '0;
              next_s.chain_out_n = 1'b0;
              next_s.done_drive_low = 1'b0;
              next_s.state = two_images ? st_forward : st_done;
            end
          end
        end
        st_forward: begin
          if (fclk) begin
            next_s.bit_count = s.bit_count + 32'h1;
            if (s.bit_count == 32'(image_words * 8 - 1)) begin
              next_s.state = st_done;
            end
          end
        end
        st_done: begin
          if (!self_fetch && s.word_count == 32'(image_words)) begin
            next_s.chain_out_n = 1'b0;
            next_s.done_drive_low = 1'b0;
          end
        end
        st_error: begin
          next_s.error_drive_low = 1'b1;
          next_s.wait_count = s.wait_count + 16'h1;
          if (auto_restart && s.wait_count == 16'(restart_cycles - 1)) begin
            next_s.state = st_reset;
            next_s.error_drive_low = 1'b0;
          end
        end
        default: begin
          next_s.state = st_reset;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{state: st_reset, chain_out_n: 1'b1, done_drive_low: 1'b1, default: '0};
      buf_cnt <= '0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      fclk <= 1'b0;
    end else begin
      s <= next_s;
      buf_cnt <= next_buf_cnt;
      buf_wp <= next_buf_wp;
      buf_rp <= next_buf_rp;
      fclk <= next_fclk;
    end
  end
  always_ff @(posedge core_clk) begin
    if (new_word && buf_in_ready) begin
      buf_mem[buf_wp] <= '{data: link.word};
    end
  end
  assign cfg_valid = buf_cnt != 2'h0;
  assign cfg_word = buf_mem[buf_rp].data;
  assign image_compressed = s.compressed;
  wire logic fetching = s.state == st_fetch;
  wire logic forwarding = s.state == st_forward;
  assign chain_enable_out_n = fetching ? 1'b1 : s.chain_out_n;
  assign flash_select_n = !(fetching || forwarding);
  assign flash_command_out = 1'b0;
  assign fetch_clock_out = (fetching || forwarding) & fclk;
  assign fetch_data_out = s.data_sync[1];
  assign fwd_clock_out = forwarding & fclk;
  assign fwd_data_out = s.data_sync[1];
  assign load_complete_out = 1'b0;
  assign load_complete_oe = s.done_drive_low;
  assign error_status_out = 1'b0;
  assign error_status_oe = s.error_drive_low;

  ceo_during_fetch_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    fetching |-> chain_enable_out_n) else $error("chain out low in fetch");
  reset_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !s.req_sync[1] |=> s.state == st_reset) else $error("not reset");
  flash_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    s.ce_sync[1] && s.state != st_forward |=> flash_select_n) else $error("flash used");
  error_low_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    s.state == st_error |-> error_status_oe) else $error("error not driven");
  done_release_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !chain_enable_out_n |-> !load_complete_oe) else $error("done held");
  clock_toggle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    fclk |=> !fclk) else $error("clock stuck");
  buf_bound_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    buf_cnt <= 2'h2) else $error("buffer overflow");
  forward_after_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    forwarding |-> !chain_enable_out_n) else $error("forward w/o enable");
  c_fetch_c: cover property (@(posedge core_clk) disable iff (!reset_n) fetching ##1 forwarding);
  c_error_c: cover property (@(posedge core_clk) disable iff (!reset_n) s.state == st_error);
  c_full_c: cover property (@(posedge core_clk) disable iff (!reset_n) buf_cnt == 2'h2);
endmodule

// ===== sim/host_link_model.sv
`timescale 1ns/100ps
module host_link_model (
  output logic config_clock,
  output logic serial_data_in
);
  initial begin
    config_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // Sends a byte low bit first, one bit per rising edge of a 48 ns clock.
  task automatic send_byte(input logic [7:0] value);
    int i;
    for (i = 0; i < 8; i++) begin
      serial_data_in = value[i];
      #24 config_clock = 1'b1;
      #24 config_clock = 1'b0;
    end
    // The clock stands still and the data line stops showing the last bit.
    serial_data_in = ~value[7];
  endtask
endmodule

// ===== sim/chained_serial_config_load_tb_top.sv
`timescale 1ns/100ps
module chained_serial_config_load_tb_top;
  import chain_load_pkg::*;
  logic core_clk, reset_n, config_clock, serial_data_in, frame_error, cfg_ready;
  logic chain_enable_in_n, config_request_n, stall, watch;
  logic chain_enable_out_n, load_complete_out, load_complete_oe, error_status_out;
  logic error_status_oe, flash_select_n, cfg_valid, image_compressed;
  logic [7:0] cfg_word;
  logic [1:0] mode_pins;
  logic [15:0] seed;
  logic [7:0] exp_q[$];
  int err_total, check_count;
  chained_serial_config_load #(.image_words(4), .restart_cycles(10)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .config_clock(config_clock),
    .mode_select_pins(mode_pins), .chain_enable_in_n(chain_enable_in_n),
    .config_request_n(config_request_n), .serial_data_in(serial_data_in),
    .frame_error(frame_error), .chain_enable_out_n(chain_enable_out_n),
    .load_complete_out(load_complete_out), .load_complete_oe(load_complete_oe),
    .error_status_out(error_status_out), .error_status_oe(error_status_oe),
    .flash_select_n(flash_select_n), .flash_command_out(), .fetch_clock_out(),
    .fetch_data_out(), .fwd_clock_out(), .fwd_data_out(), .cfg_word(cfg_word),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .image_compressed(image_compressed));
  host_link_model i_host (.config_clock(config_clock), .serial_data_in(serial_data_in));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic finish_test();
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic load_image(input logic comp);
    int k;
    logic [7:0] b;
    for (k = 0; k < 4; k++) begin
      b = seed[7:0];
      if (k == 0) b[7] = comp;
      exp_q.push_back(b);
      i_host.send_byte(b);
      if (k == 1) begin
        repeat (10) @(posedge core_clk);
        cmp_bit(cfg_valid, 1'b1);
        stall <= 1'b0;
      end
    end
    for (k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    cmp_bit(exp_q.size() == 0, 1'b1);
    cmp_bit(image_compressed, comp);
    cmp_bit(load_complete_oe, 1'b0);
    cmp_bit(chain_enable_out_n, 1'b0);
  endtask
  task automatic req_pulse();
    @(posedge core_clk) config_request_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    cmp_bit(load_complete_oe, 1'b1);
    config_request_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    seed <= lfsr_next(seed);
    cfg_ready <= stall ? 1'b0 : seed[0];
    if (watch && cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
      if (exp_q.size() != 0) cmp_byte(cfg_word, exp_q.pop_front());
      else cmp_bit(1'b1, 1'b0);
    end
  end
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  initial begin
    reset_n = 1'b0;
    seed = 16'h0ed5;
    mode_pins = 2'h1;
    cfg_ready = 1'b0;
    frame_error = 1'b0;
    stall = 1'b1;
    watch = 1'b1;
    err_total = 0;
    check_count = 0;
    chain_enable_in_n = 1'b1;
    config_request_n = 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    cmp_bit(chain_enable_out_n, 1'b1);
    i_host.send_byte(8'h5a);
    cmp_bit(flash_select_n, 1'b1);
    cmp_bit(load_complete_oe, 1'b1);
    @(posedge core_clk) config_request_n <= 1'b1;
    i_host.send_byte(8'ha5);
    repeat (10) @(posedge core_clk);
    cmp_bit(cfg_valid, 1'b0);
    chain_enable_in_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    load_image(1'b1);
    req_pulse();
    watch = 1'b0;
    i_host.send_byte(8'h3c);
    @(posedge core_clk) frame_error <= 1'b1;
    @(posedge core_clk) frame_error <= 1'b0;
    repeat (3) @(posedge core_clk);
    cmp_bit(error_status_oe, 1'b1);
    repeat (20) @(posedge core_clk);
    cmp_bit(error_status_oe, 1'b0);
    req_pulse();
    watch = 1'b1;
    stall <= 1'b1;
    load_image(1'b0);
    mode_pins <= 2'h0;
    req_pulse();
    repeat (2) @(posedge core_clk);
    cmp_bit(flash_select_n, 1'b0);
    cmp_bit(chain_enable_out_n, 1'b1);
    repeat (200) @(posedge core_clk);
    cmp_bit(chain_enable_out_n, 1'b0);
    cmp_bit(flash_select_n, 1'b1);
    finish_test();
  end
endmodule
